/* File: fpc_top.sv */
// Flash program/erase control: control, status, block select and unit address registers
// Assumes an APB master on clk_sys; protect, mode and port pins arrive asynchronously
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.

module fpc_top
  import fpc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              protect_pin,
  input  wire logic              mode_pin_0,
  input  wire logic              mode_pin_1,
  input  wire logic              err_event,
  input  wire logic              sci_txd,
  input  wire logic              gpio_a9_out,
  input  wire logic              gpio_a9_oe,
  input  wire logic              port_a_bit8_pin,
  output logic                   port_a_bit9_pin_o,
  output logic                   port_a_bit9_pin_oe,
  output logic                   serial_rx_pin,
  output logic                   gpio_a8_in,
  output fpc_state_t             array_state,
  output logic [NUM_BLK-1:0]     erase_block_sel,
  output fpc_erase_t             erase_range,
  output logic [FA_W-1:0]        prog_unit_addr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic              prot_s1_reg, prot_s2_reg;
  logic [1:0]        md_s1_reg, md_s2_reg, md_reg, md_next;
  logic [1:0]        cap_cnt_reg, cap_cnt_next;
  logic              p8_s1_reg, p8_s2_reg;
  logic [6:0]        ctrl_reg, ctrl_next;
  logic [EBLO_W-1:0] eblo_reg, eblo_next;
  logic [EBHI_W-1:0] ebhi_reg, ebhi_next;
  logic [FA_W-1:0]   unit_reg, unit_next;
  logic              flash_error_flag_reg, flash_error_flag_next;
  fpc_state_t        state_reg, state_next;
  fpc_erase_t        erase_reg, erase_next;
  logic [31:0]       prdata_reg, prdata_next;
  logic              pready_reg, pready_next;
  logic              pslverr_reg, pslverr_next;
  logic              p9_o_reg, p9_o_next, p9_oe_reg, p9_oe_next;
  logic              srx_reg, srx_next;

  logic              permit, cap_done, prog_ok, ena, acc, done, hit;
  logic              sw_en_next;
  logic [NUM_BLK-1:0] eb_all;

  function automatic logic [3:0] ones(input logic [NUM_BLK-1:0] v);
    ones = '0;
    for (int i = 0; i < NUM_BLK; i++)
      ones = ones + 4'(v[i]);
  endfunction

  // ----------------------------------------------------------------
  // Common terms
  // ----------------------------------------------------------------
  always_comb
  begin
    permit   = ~prot_s2_reg;                                   // R1
    cap_done = (cap_cnt_reg == CAP_CYC);
    prog_ok  = cap_done && (md_reg != MD_USER_RO);             // R19
    ena      = ctrl_reg[BIT_SWEN] && permit && prog_ok;        // R2
    acc      = psel && penable;
    done     = acc && pready_reg;
    hit      = (paddr == OFS_CTRL) || (paddr == OFS_STAT) || (paddr == OFS_EBLO)
               || (paddr == OFS_EBHI) || (paddr == OFS_UNIT);
    eb_all   = {ebhi_reg, eblo_reg};
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and mode capture
  // ----------------------------------------------------------------
  always_comb
  begin
    cap_cnt_next = cap_done ? cap_cnt_reg : cap_cnt_reg + 2'h1;
    md_next      = cap_done ? md_reg : md_s2_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prot_s1_reg <= 1'b1;
      prot_s2_reg <= 1'b1;
      md_s1_reg   <= 2'h0;
      md_s2_reg   <= 2'h0;
      md_reg      <= 2'h0;
      cap_cnt_reg <= 2'h0;
      p8_s1_reg   <= 1'b1;
      p8_s2_reg   <= 1'b1;
    end
    else
    begin
      prot_s1_reg <= protect_pin;
      prot_s2_reg <= prot_s1_reg;
      md_s1_reg   <= {mode_pin_1, mode_pin_0};
      md_s2_reg   <= md_s1_reg;
      md_reg      <= md_next;
      cap_cnt_reg <= cap_cnt_next;
      p8_s1_reg   <= port_a_bit8_pin;
      p8_s2_reg   <= p8_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Control, block select, unit address and error flag
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_next = ctrl_reg;
    eblo_next = eblo_reg;
    ebhi_next = ebhi_reg;
    unit_next = unit_reg;
    flash_error_flag_next = flash_error_flag_reg;
    sw_en_next = ctrl_reg[BIT_SWEN];
    if (done && pwrite && paddr == OFS_CTRL)
      sw_en_next = pwdata[BIT_SWEN];
    if (!ena)
      ctrl_next = '0;                                          // R3
    else if (done && pwrite && paddr == OFS_CTRL)
    begin
      ctrl_next[BIT_ERSU] = pwdata[BIT_ERSU];                  // R4
      ctrl_next[BIT_PRSU] = pwdata[BIT_PRSU];                  // R5
      ctrl_next[BIT_ERVF] = pwdata[BIT_ERVF];                  // R6
      ctrl_next[BIT_PRVF] = pwdata[BIT_PRVF];                  // R7
      ctrl_next[BIT_E]    = pwdata[BIT_E] && ctrl_reg[BIT_ERSU] && !flash_error_flag_reg;  // R8
      ctrl_next[BIT_P]    = pwdata[BIT_P] && ctrl_reg[BIT_PRSU] && !flash_error_flag_reg;  // R9
    end
    ctrl_next[BIT_E]    = ctrl_next[BIT_E] && ctrl_next[BIT_ERSU];  // R8
    ctrl_next[BIT_P]    = ctrl_next[BIT_P] && ctrl_next[BIT_PRSU];  // R9
    ctrl_next[BIT_SWEN] = sw_en_next;
    if (!(ctrl_reg[BIT_SWEN] && permit))
    begin
      eblo_next = '0;                                          // R17
      ebhi_next = '0;                                          // R17
    end
    else if (done && pwrite)
    begin
      if (paddr == OFS_EBLO)
        eblo_next = pwdata[EBLO_W-1:0];                        // R3
      if (paddr == OFS_EBHI)
        ebhi_next = pwdata[EBHI_W-1:0];                        // R3
      if (ones({ebhi_next, eblo_next}) > 4'h1)
      begin
        eblo_next = '0;                                        // R18
        ebhi_next = '0;                                        // R18
      end
    end
    if (ena && done && pwrite && paddr == OFS_UNIT)
      unit_next = {pwdata[FA_W-1:UNIT_LSB], UNIT_LSB'(0)};     // R12
    if (err_event && (state_reg == ST_ERASE || state_reg == ST_PROGRAM))
      flash_error_flag_next = 1'b1;                                        // R10
  end

  // Array mode: one state by priority, read when all bits clear
  always_comb
  begin
    if (ctrl_next[BIT_P])
      state_next = ST_PROGRAM;                                 // R9
    else if (ctrl_next[BIT_E])
      state_next = ST_ERASE;                                   // R8
    else if (ctrl_next[BIT_PRVF])
      state_next = ST_PVERIFY;                                 // R7
    else if (ctrl_next[BIT_ERVF])
      state_next = ST_EVERIFY;                                 // R6
    else if (ctrl_next[BIT_PRSU])
      state_next = ST_PSETUP;                                  // R5
    else if (ctrl_next[BIT_ERSU])
      state_next = ST_ESETUP;                                  // R4
    else
      state_next = ST_READ;                                    // R20
  end

  // Erase range of the selected block
  always_comb
  begin
    erase_next        = '0;
    erase_next.fill   = ERASED_BYTE;                           // R14
    for (int i = 0; i < NUM_BLK; i++)
      if (eb_all[i])
      begin
        erase_next.base = blk_base(i);                         // R13
        erase_next.last = blk_base(i) + blk_size(i) - FA_W'(1);  // R14
      end
    erase_next.active = (state_reg == ST_ERASE) && (eb_all != '0);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg  <= CTRL_RST[6:0];
      eblo_reg  <= EB_RST;
      ebhi_reg  <= EB_RST[EBHI_W-1:0];
      unit_reg  <= '0;
      flash_error_flag_reg  <= 1'b0;
      state_reg <= ST_READ;
      erase_reg <= '0;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      eblo_reg  <= eblo_next;
      ebhi_reg  <= ebhi_next;
      unit_reg  <= unit_next;
      flash_error_flag_reg  <= flash_error_flag_next;
      state_reg <= state_next;
      erase_reg <= erase_next;
    end
  end

  // ----------------------------------------------------------------
  // APB slave and shared port pins
  // ----------------------------------------------------------------
  always_comb
  begin
    pready_next  = acc && !pready_reg;
    prdata_next  = RD_ZERO;
    pslverr_next = pready_next && !hit;
    if (pready_next && !pwrite)
      unique case (paddr)
        OFS_CTRL: prdata_next[7:0] = {permit, ctrl_reg};       // R1
        OFS_STAT: prdata_next[BIT_ERRF] = flash_error_flag_reg;            // R11
        OFS_EBLO: prdata_next[EBLO_W-1:0] = eblo_reg;
        OFS_EBHI: prdata_next[EBHI_W-1:0] = ebhi_reg;
        OFS_UNIT: prdata_next[FA_W-1:0] = unit_reg;
        default:  prdata_next = RD_ZERO;
      endcase
    if (cap_done && md_reg == MD_BOOT)
    begin
      p9_o_next   = sci_txd;                                   // R16
      p9_oe_next  = 1'b1;                                      // R16
      srx_next    = p8_s2_reg;                                 // R16
    end
    else
    begin
      p9_o_next   = gpio_a9_out;
      p9_oe_next  = gpio_a9_oe;
      srx_next    = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_reg  <= RD_ZERO;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      p9_o_reg    <= 1'b0;
      p9_oe_reg   <= 1'b0;
      srx_reg     <= 1'b1;
      gpio_a8_in  <= 1'b1;
    end
    else
    begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      p9_o_reg    <= p9_o_next;
      p9_oe_reg   <= p9_oe_next;
      srx_reg     <= srx_next;
      gpio_a8_in  <= p8_s2_reg;
    end
  end

  always_comb
  begin
    prdata             = prdata_reg;
    pready             = pready_reg;
    pslverr            = pslverr_reg;
    port_a_bit9_pin_o  = p9_o_reg;
    port_a_bit9_pin_oe = p9_oe_reg;
    serial_rx_pin      = srx_reg;
    array_state        = state_reg;
    erase_block_sel    = eb_all;
    erase_range        = erase_reg;
    prog_unit_addr     = unit_reg;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence ctrl_read_s;
    done && !pwrite && paddr == OFS_CTRL;
  endsequence

  sequence boot_s;
    cap_done && md_reg == MD_BOOT;
  endsequence

  chk_permit_reads_pin: assert property (ctrl_read_s |-> // R1
    prdata[BIT_PWPF] == !$past(prot_s2_reg))
    else $error("write permit flag does not mirror protect pin");
  chk_mode_needs_we: assert property (state_reg != ST_READ |-> $past(ena)) // R2
    else $error("array left read mode without both write enables");
  chk_bits_locked: assert property (!ctrl_reg[BIT_SWEN] |=> // R3
    ctrl_reg[BIT_ERSU:BIT_P] == '0)
    else $error("control bit held while software enable clear");
  chk_erase_entry: assert property ($rose(ctrl_reg[BIT_E]) |-> // R8
    $past(ctrl_reg[BIT_ERSU] && ena))
    else $error("erase entered without setup and enables");
  chk_prog_entry: assert property ($rose(ctrl_reg[BIT_P]) |-> // R9
    $past(ctrl_reg[BIT_PRSU] && ena))
    else $error("program entered without setup and enables");
  chk_error_sets: assert property (err_event && // R10
    (state_reg == ST_ERASE || state_reg == ST_PROGRAM) |=> flash_error_flag_reg [*2])
    else $error("error flag not set and held");
  chk_stat_reserved: assert property (done && !pwrite && paddr == OFS_STAT |-> // R11
    prdata[6:0] == '0)
    else $error("reserved status bits not zero");
  chk_unit_align: assert property (unit_reg[UNIT_LSB-1:0] == '0) // R12
    else $error("program unit not 128-byte aligned");
  chk_erase_fill: assert property (erase_range.active |-> // R14
    $past(state_reg) == ST_ERASE && erase_range.fill == ERASED_BYTE)
    else $error("erase range active outside erase or fill value wrong");
  chk_eb_clear: assert property (prot_s2_reg || !ctrl_reg[BIT_SWEN] |=> eb_all == '0) // R17
    else $error("block select not cleared");
  chk_eb_single: assert property ($countones(eb_all) <= 1) // R18
    else $error("more than one erase block selected");
  chk_user_readonly: assert property (cap_done && md_reg == MD_USER_RO |-> // R19
    state_reg == ST_READ)
    else $error("program or erase in plain user mode");
  chk_boot_pins: assert property (boot_s ##1 boot_s |-> // R16
    port_a_bit9_pin_oe && serial_rx_pin == $past(p8_s2_reg))
    else $error("boot mode port pins not given to serial");
  chk_one_mode: assert property ($onehot(state_reg) and // R20
    (ctrl_reg[BIT_ERSU:BIT_P] == '0 |-> state_reg == ST_READ))
    else $error("mode state not single or not read");

endmodule

/* File: fpc_pkg.sv */
// Constants, types and helper functions for the flash program/erase control block
// Assumes an APB slave context, a 40 MHz system clock and an asynchronous active-low reset
//
// Functional notes
// R1: Control bit 7 reads 1 while protect pin is low, 0 while high.
// R2: Program and erase allowed only with software and pin write enables both 1.
// R3: Software enable 0 prevents setting any other control bit or block select bit.
// R4: Erase-setup bit set with both enables enters erase setup; clearing cancels.
// R5: Program-setup bit set with both enables enters program setup; clearing cancels.
// R6: Erase-verify bit set with both enables enters erase-verify; clearing leaves it.
// R7: Program-verify bit set with both enables enters program-verify; clearing leaves it.
// R8: Erase bit enters erase mode only with both enables and erase setup set.
// R9: Program bit enters program mode only with both enables and program setup set.
// R10: Status bit 7 sets when program or erase hits the error-protection state.
// R11: Status bits 6 to 0 are reserved and always read 0.
// R12: Programming uses 128-byte units starting at low address byte 00 or 80.
// R13: Twelve erase blocks: three 64K, one 32K, eight 4K, each erased whole.
// R14: Erase covers whole blocks only and leaves every byte reading FF.
// R15: Software must only program blocks that were erased before.
// R16: In boot mode the two shared port pins serve the serial transmit and receive.
// R17: Both block select registers clear while protect pin high or software enable 0.
// R18: More than one block select bit set clears all bits of both registers.
// R19: Plain user mode allows reading only, no program and no erase.
// R20: At most one of program, erase and verify modes active; all bits 0 is read.

package fpc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0]  OFS_CTRL = 8'h00;
  localparam logic [7:0]  OFS_STAT = 8'h04;
  localparam logic [7:0]  OFS_EBLO = 8'h08;
  localparam logic [7:0]  OFS_EBHI = 8'h0c;
  localparam logic [7:0]  OFS_UNIT = 8'h10;

  localparam int BIT_PWPF = 7;
  localparam int BIT_SWEN = 6;
  localparam int BIT_ERSU = 5;
  localparam int BIT_PRSU = 4;
  localparam int BIT_ERVF = 3;
  localparam int BIT_PRVF = 2;
  localparam int BIT_E    = 1;
  localparam int BIT_P    = 0;
  localparam int BIT_ERRF = 7;

  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  EB_RST   = 8'h00;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int          FA_W      = 18;
  localparam int          UNIT_LSB  = 7;
  localparam int          NUM_BLK   = 12;
  localparam int          EBLO_W    = 8;
  localparam int          EBHI_W    = 4;
  localparam logic [FA_W-1:0] SMALL_SZ = 18'h01000;
  localparam logic [FA_W-1:0] MID_BASE = 18'h08000;
  localparam logic [FA_W-1:0] MID_SZ   = 18'h08000;
  localparam logic [FA_W-1:0] BIG_BASE = 18'h10000;
  localparam logic [FA_W-1:0] BIG_SZ   = 18'h10000;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;

  // ----------------------------------------------------------------
  // Operating mode pins and capture
  // ----------------------------------------------------------------
  localparam logic [1:0] MD_USER_RO = 2'h3;
  localparam logic [1:0] MD_BOOT    = 2'h2;
  localparam logic [1:0] CAP_CYC    = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_READ    = 7'h01,
    ST_ESETUP  = 7'h02,
    ST_PSETUP  = 7'h04,
    ST_EVERIFY = 7'h08,
    ST_PVERIFY = 7'h10,
    ST_ERASE   = 7'h20,
    ST_PROGRAM = 7'h40
  } fpc_state_t;

  typedef struct packed {
    logic            active;
    logic [FA_W-1:0] base;
    logic [FA_W-1:0] last;
    logic [7:0]      fill;
  } fpc_erase_t;

  // ----------------------------------------------------------------
  // Block table
  // ----------------------------------------------------------------
  function automatic logic [FA_W-1:0] blk_size(input int idx);
    if (idx < EBLO_W)
      blk_size = SMALL_SZ;
    else if (idx == EBLO_W)
      blk_size = MID_SZ;
    else
      blk_size = BIG_SZ;
  endfunction

  function automatic logic [FA_W-1:0] blk_base(input int idx);
    logic [FA_W-1:0] k;
    k = FA_W'(idx - EBLO_W - 1);
    if (idx < EBLO_W)
      blk_base = SMALL_SZ * FA_W'(idx);
    else if (idx == EBLO_W)
      blk_base = MID_BASE;
    else
      blk_base = BIG_BASE + BIG_SZ * k;
  endfunction

endpackage

/* File: tb_flash_program_erase_control.sv */
// Self-checking bench for the flash program/erase control block
// Assumes fpc_pkg and fpc_top are compiled first; APB master, pins and events driven here
module tb_flash_program_erase_control;
  import fpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk_sys;
  logic              rst_n;
  logic [ADDR_W-1:0] paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              protect_pin;
  logic              mode_pin_0;
  logic              mode_pin_1;
  logic              err_event;
  logic              sci_txd;
  logic              gpio_a9_out;
  logic              gpio_a9_oe;
  logic              port_a_bit8_pin;
  logic              port_a_bit9_pin_o;
  logic              port_a_bit9_pin_oe;
  logic              serial_rx_pin;
  logic              gpio_a8_in;
  fpc_state_t        array_state;
  logic [NUM_BLK-1:0] erase_block_sel;
  fpc_erase_t        erase_range;
  logic [FA_W-1:0]   prog_unit_addr;
  int                errors;
  int                checks;
  int                cycles;
  logic [31:0]       rd;
  logic              last_err;
  logic [7:0]        rv;

  fpc_top dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .protect_pin(protect_pin), .mode_pin_0(mode_pin_0), .mode_pin_1(mode_pin_1),
    .err_event(err_event), .sci_txd(sci_txd), .gpio_a9_out(gpio_a9_out),
    .gpio_a9_oe(gpio_a9_oe), .port_a_bit8_pin(port_a_bit8_pin),
    .port_a_bit9_pin_o(port_a_bit9_pin_o), .port_a_bit9_pin_oe(port_a_bit9_pin_oe),
    .serial_rx_pin(serial_rx_pin), .gpio_a8_in(gpio_a8_in), .array_state(array_state),
    .erase_block_sel(erase_block_sel), .erase_range(erase_range),
    .prog_unit_addr(prog_unit_addr)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [44:0] exp, input logic [44:0] got);
    checks = checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic do_reset(input logic [1:0] md);
    rst_n      <= 1'b0;
    mode_pin_0 <= md[0];
    mode_pin_1 <= md[1];
    cyc(10);
    rst_n <= 1'b1;
    cyc(6);
  endtask

  function automatic logic [7:0] sel_exp(input logic [7:0] v);
    return ($countones(v) == 1) ? v : 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    protect_pin = 1'b0;
    mode_pin_0 = 1'b0;
    mode_pin_1 = 1'b0;
    err_event = 1'b0;
    sci_txd = 1'b0;
    gpio_a9_out = 1'b1;
    gpio_a9_oe = 1'b1;
    port_a_bit8_pin = 1'b0;
    rv = 8'($urandom(3785));
    @(posedge clk_sys);
    do_reset(2'h0);
    // Reset values, reserved status bits, unmapped access
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_reset", 45'h80, rd);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("stat_reset", 45'h0, rd);
    apb(1'b1, OFS_STAT, 32'hff);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("stat_ro", 45'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", 45'h1, {44'h0, last_err});
    // Enable off: other bits and selects cannot be set
    apb(1'b1, OFS_EBLO, 32'h04);
    apb(1'b0, OFS_EBLO, 32'h0);
    chk("ebl_locked", 45'h0, rd);
    apb(1'b1, OFS_CTRL, 32'h7f);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_swe_only", 45'hc0, rd);
    // Setup and verify bits, each then cleared
    apb(1'b1, OFS_CTRL, 32'h60);
    cyc(1);
    chk("st_esetup", 45'(ST_ESETUP), 45'(array_state));
    apb(1'b1, OFS_CTRL, 32'h50);
    cyc(1);
    chk("st_psetup", 45'(ST_PSETUP), 45'(array_state));
    apb(1'b1, OFS_CTRL, 32'h48);
    cyc(1);
    chk("st_everify", 45'(ST_EVERIFY), 45'(array_state));
    apb(1'b1, OFS_CTRL, 32'h44);
    cyc(1);
    chk("st_pverify", 45'(ST_PVERIFY), 45'(array_state));
    apb(1'b1, OFS_CTRL, 32'h40);
    cyc(1);
    chk("st_read", 45'(ST_READ), 45'(array_state));
    // Erase and program without their setup bit are refused
    apb(1'b1, OFS_CTRL, 32'h42);
    cyc(1);
    chk("erase_no_setup", 45'(ST_READ), 45'(array_state));
    apb(1'b1, OFS_CTRL, 32'h41);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("prog_no_setup", 45'hc0, rd);
    apb(1'b1, OFS_CTRL, 32'h50);
    apb(1'b1, OFS_CTRL, 32'h51);
    cyc(1);
    chk("st_program", 45'(ST_PROGRAM), 45'(array_state));
    apb(1'b1, OFS_CTRL, 32'h40);
    // Block select: one bit kept, several cleared, random values
    for (int i = 0; i < 10; i++)
    begin
      rv = (i == 0) ? 8'h18 : ((i == 1) ? 8'h80 : 8'($urandom));
      apb(1'b1, OFS_EBLO, {24'h0, rv});
      apb(1'b0, OFS_EBLO, 32'h0);
      chk("ebl_rand", 45'(sel_exp(rv)), rd);
    end
    apb(1'b1, OFS_EBLO, 32'h01);
    apb(1'b1, OFS_EBHI, 32'h02);
    cyc(1);
    chk("eb_cross", 45'h0, 45'(erase_block_sel));
    apb(1'b1, OFS_EBHI, 32'h04);
    apb(1'b1, OFS_CTRL, 32'h60);
    apb(1'b1, OFS_CTRL, 32'h62);
    cyc(2);
    chk("st_erase", 45'(ST_ERASE), 45'(array_state));
    chk("range", {1'b1, 18'h20000, 18'h2ffff, 8'hff}, 45'(erase_range));
    apb(1'b1, OFS_CTRL, 32'h40);
    apb(1'b1, OFS_EBHI, 32'h00);
    apb(1'b1, OFS_EBLO, 32'h08);
    apb(1'b1, OFS_CTRL, 32'h60);
    apb(1'b1, OFS_CTRL, 32'h62);
    cyc(2);
    chk("range_small", {1'b1, 18'h03000, 18'h03fff, 8'hff}, 45'(erase_range));
    // Error event during erase sets the status flag
    err_event <= 1'b1;
    cyc(1);
    err_event <= 1'b0;
    apb(1'b0, OFS_STAT, 32'h0);
    chk("err_flag", 45'h80, rd);
    // Clearing the enable clears the selects
    apb(1'b1, OFS_CTRL, 32'h00);
    cyc(1);
    chk("eb_swe_off", 45'h0, 45'(erase_block_sel));
    // Program unit address aligned to 128 bytes
    apb(1'b1, OFS_CTRL, 32'h40);
    for (int i = 0; i < 4; i++)
    begin
      pwdata <= 32'h3000 | (32'($urandom) & 32'hfff);
      cyc(1);
      apb(1'b1, OFS_UNIT, pwdata);
      cyc(1);
      chk("unit_addr", 45'(pwdata[17:0] & 18'h3ff80), 45'(prog_unit_addr));
    end
    // Protect pin high: permit flag clears, selects clear
    apb(1'b1, OFS_EBLO, 32'h02);
    protect_pin <= 1'b1;
    cyc(4);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("permit_flag", 45'h0, 45'(rd[7]));
    chk("eb_protect", 45'h0, 45'(erase_block_sel));
    apb(1'b1, OFS_CTRL, 32'h60);
    cyc(1);
    chk("protect_block", 45'(ST_READ), 45'(array_state));
    protect_pin <= 1'b0;
    chk("rx_user", 45'h1, 45'(serial_rx_pin));
    chk("pin9_user", 45'h3, {port_a_bit9_pin_o, port_a_bit9_pin_oe});
    // Plain user mode: no program or erase
    do_reset(2'h3);
    apb(1'b1, OFS_CTRL, 32'h40);
    apb(1'b1, OFS_CTRL, 32'h60);
    cyc(1);
    chk("user_ro", 45'(ST_READ), 45'(array_state));
    // Boot mode: shared pins serve the serial link
    do_reset(2'h2);
    for (int i = 0; i < 6; i++)
    begin
      rv = 8'($urandom);
      port_a_bit8_pin <= rv[0];
      sci_txd <= rv[1];
      cyc(4);
      chk("boot_rx", 45'(rv[0]), 45'(serial_rx_pin));
      chk("pin8_in", 45'(rv[0]), 45'(gpio_a8_in));
      chk("boot_tx", 45'({rv[1], 1'b1}), {port_a_bit9_pin_o, port_a_bit9_pin_oe});
    end
    give_verdict();
  end
endmodule
